// ===== logic/iar_pkg.sv
// Shared constants and carrier types for the interrupt acknowledge read block.
package iar_pkg;

    localparam int NUM_IRQ = 32;
    localparam int ID_W = 10;
    localparam int CPU_W = 3;
    localparam int IDX_W = 5;

    // Register byte offsets on the APB.
    localparam logic [7:0] OFF_IFACE_CTRL = 8'h00;
    localparam logic [7:0] OFF_DIST_CTRL = 8'h04;
    localparam logic [7:0] OFF_GROUP = 8'h08;
    localparam logic [7:0] OFF_EDGE_CFG = 8'h0c;
    localparam logic [7:0] OFF_PENDING = 8'h10;
    localparam logic [7:0] OFF_ACTIVE = 8'h14;
    localparam logic [7:0] OFF_ACK = 8'h18;
    localparam logic [7:0] OFF_ALIAS_ACK = 8'h1c;

    // Control field positions.
    localparam int BIT_GRP0_EN = 0;
    localparam int BIT_GRP1_EN = 1;
    localparam int BIT_ACK_CTL = 2;

    // Reset values.
    localparam logic [2:0] IFACE_CTRL_RST = 3'h0;
    localparam logic [1:0] DIST_CTRL_RST = 2'h0;
    localparam logic [31:0] GROUP_RST = 32'h0000_0000;
    localparam logic [31:0] EDGE_CFG_RST = 32'h0000_0000;

    // Acknowledge value layout and special identifiers.
    localparam int ID_LSB = 0;
    localparam int CPU_LSB = 10;
    localparam logic [ID_W-1:0] ID_SPURIOUS = 10'h3ff;
    localparam logic [ID_W-1:0] ID_GRP1_ONLY = 10'h3fe;
    localparam logic [ID_W-1:0] ID_FIRST_SPECIAL = 10'h3fc;
    localparam logic [ID_W-1:0] ID_SGI_LIMIT = 10'h010;

    // Set when the interface implements the security states.
    localparam logic SECURITY_EXT = 1'b1;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [2:0] pprot;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } iar_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } iar_apb_rsp_s;

    typedef struct packed {
        logic valid;
        logic [ID_W-1:0] id;
    } iar_ack_s;

endpackage

// ===== logic/iar_pick.sv
// Highest-priority selection among eligible interrupts; the lowest identifier wins.
`timescale 1ns/1ps
module iar_pick
    import iar_pkg::*;
(
    input wire logic [NUM_IRQ-1:0] eligible,
    output logic found,
    output logic [IDX_W-1:0] index
);

    always_comb begin
        found = 1'b0;
        index = '0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                found = 1'b1;
                index = IDX_W'(i);
            end
        end
    end

endmodule // iar_pick

// ===== logic/iar_ack_read.sv
// Acknowledge-read path of a processor interrupt interface with its pending and active state.
//
// What this block does
// - Acknowledge read returns highest-priority (lowest) pending identifier
// - Identifier bits 9:0, processor bits 12:10
// - Source processor only for software interrupts
// - Return 1023 when disabled or none
// - Valid read moves pending to active
// - Level input still high keeps pending
// - Only one interface gets each latched interrupt; a still-high level one is masked only while peer_claim is set
// - Disabled group reads as no interrupt
// - Group 0: non-secure 1023, secure identifier
// - Group 1 secure without ack control: 1022
// - Without security, group 1 needs ack control
// - Side effect only below 1020
// - Shared register plus non-secure alias view
`timescale 1ns/1ps
module iar_ack_read
    import iar_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire iar_apb_req_s apb_req,
    output iar_apb_rsp_s apb_rsp,
    input wire logic [NUM_IRQ-1:0] irq_in,
    input wire logic prio_ok,
    input wire logic sgi_req,
    input wire logic [3:0] sgi_id,
    input wire logic [CPU_W-1:0] sgi_src,
    input wire logic [NUM_IRQ-1:0] peer_claim,
    output iar_ack_s ack_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register state.

    logic [2:0] iface_ctrl_q;
    logic [1:0] dist_ctrl_q;
    logic [NUM_IRQ-1:0] group_q;
    logic [NUM_IRQ-1:0] edge_cfg_q;
    logic [NUM_IRQ-1:0] latch_q;
    logic [NUM_IRQ-1:0] active_q;
    logic [CPU_W-1:0] sgi_src_q [16];
    logic [NUM_IRQ-1:0] irq_meta_q;
    logic [NUM_IRQ-1:0] irq_sync_q;
    logic [NUM_IRQ-1:0] irq_prev_q;

    logic access;
    logic wr_en;
    logic rd_ack;
    logic rd_alias;
    logic mapped;
    logic nonsecure_access;
    logic [31:0] ack_val;
    logic take;
    logic [NUM_IRQ-1:0] take_vec;
    logic [NUM_IRQ-1:0] edge_rise;
    logic [NUM_IRQ-1:0] pend_eff;
    logic [NUM_IRQ-1:0] eligible;
    logic hp_found;
    logic [IDX_W-1:0] hp_index;
    logic [31:0] rd_data;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode. One wait state lets every response leave a flip-flop.

    assign access = apb_req.psel && apb_req.penable && !apb_rsp.pready;
    assign wr_en = access && apb_req.pwrite;
    assign rd_ack = access && !apb_req.pwrite && apb_req.paddr == OFF_ACK;
    assign rd_alias = access && !apb_req.pwrite && apb_req.paddr == OFF_ALIAS_ACK;
    // APB protection bit 1 marks a non-secure access.
    assign nonsecure_access = apb_req.pprot[1];

    // True when the access phase of a write targets the given offset.
    function automatic logic wr_hit(input logic [7:0] off);
        wr_hit = wr_en && apb_req.paddr == off;
    endfunction

    // A group is signalled only while both the distributor and the interface enable it.
    function automatic logic grp_on(input logic grp1);
        if (grp1) begin
            grp_on = dist_ctrl_q[BIT_GRP1_EN] && iface_ctrl_q[BIT_GRP1_EN];
        end else begin
            grp_on = dist_ctrl_q[BIT_GRP0_EN] && iface_ctrl_q[BIT_GRP0_EN];
        end
    endfunction

    always_comb begin
        case (apb_req.paddr)
            OFF_IFACE_CTRL, OFF_DIST_CTRL, OFF_GROUP, OFF_EDGE_CFG,
            OFF_PENDING, OFF_ACTIVE: begin
                mapped = 1'b1;
            end
            // The acknowledge registers are read-only; a write is an error.
            OFF_ACK, OFF_ALIAS_ACK: begin
                mapped = !apb_req.pwrite;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers and pending state.

    // Only the second and third stages feed logic; the first may still be settling.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            irq_meta_q <= '0;
            irq_sync_q <= '0;
            irq_prev_q <= '0;
        end else begin
            irq_meta_q <= irq_in;
            irq_sync_q <= irq_meta_q;
            irq_prev_q <= irq_sync_q;
        end
    end

    // The history resets to the idle level of the lines, so no false edge follows reset.
    assign edge_rise = irq_sync_q & ~irq_prev_q;
    // A level interrupt stays pending for as long as its input is high.
    assign pend_eff = latch_q | (irq_sync_q & ~edge_cfg_q);
    // A peer taking an interrupt in this cycle removes it from our choice.
    assign eligible = pend_eff & ~active_q & ~peer_claim & {NUM_IRQ{prio_ok}};

    iar_pick u_pick (
        .eligible(eligible),
        .found(hp_found),
        .index(hp_index)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Acknowledge value. Shared by the common register and its alias.

    function automatic logic [31:0] ack_value(input logic ns);
        logic [ID_W-1:0] id;
        logic grp1;
        logic ns_eff;
        logic [CPU_W-1:0] cpu;
        id = {{(ID_W-IDX_W){1'b0}}, hp_index};
        grp1 = group_q[hp_index];
        // Without security every access behaves as a secure one.
        ns_eff = SECURITY_EXT && ns;
        cpu = '0;
        if (!hp_found) begin
            id = ID_SPURIOUS;
        end else if (!grp_on(grp1)) begin
            id = ID_SPURIOUS;
        end else if (!grp1) begin
            if (ns_eff) begin
                id = ID_SPURIOUS;
            end
        end else if (!ns_eff && !iface_ctrl_q[BIT_ACK_CTL]) begin
            id = ID_GRP1_ONLY;
        end
        if (id < ID_SGI_LIMIT) begin
            cpu = sgi_src_q[id[3:0]];
        end
        ack_value = 32'h0000_0000;
        ack_value[CPU_LSB +: CPU_W] = cpu;
        ack_value[ID_LSB +: ID_W] = id;
    endfunction

    // The alias always presents the non-secure view, whoever reads it.
    // A continuous assignment would not follow the state that the function reads, so this is a process.
    always_comb begin
        if (rd_alias) begin
            ack_val = ack_value(1'b1);
        end else begin
            ack_val = ack_value(nonsecure_access);
        end
    end
    assign take = (rd_ack || rd_alias) && ack_val[ID_LSB +: ID_W] < ID_FIRST_SPECIAL;

    always_comb begin
        take_vec = '0;
        take_vec[hp_index] = take;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-interrupt pending latch and active flag; a set always beats a clear.

    for (genvar i = 0; i < NUM_IRQ; i++) begin : g_irq
        logic set_pend;
        logic clr_pend;
        logic clr_act;
        assign set_pend = (edge_cfg_q[i] && edge_rise[i])
            || (sgi_req && i < 16 && sgi_id == 4'(i))
            || (wr_en && apb_req.paddr == OFF_PENDING && apb_req.pwdata[i]);
        // Acknowledge clears the latched pending; a level input still high keeps the interrupt pending without setting the latch.
        assign clr_pend = take_vec[i] || peer_claim[i];
        assign clr_act = wr_en && apb_req.paddr == OFF_ACTIVE && apb_req.pwdata[i];

        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                latch_q[i] <= 1'b0;
            end else if (set_pend) begin
                latch_q[i] <= 1'b1;
            end else if (clr_pend) begin
                latch_q[i] <= 1'b0;
            end
        end

        // Software deactivation stands in for the completion path, which lies outside this block.
        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                active_q[i] <= 1'b0;
            end else if (take_vec[i]) begin
                active_q[i] <= 1'b1;
            end else if (clr_act) begin
                active_q[i] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Source processor of each software-generated interrupt.
    // A repeated request for one number keeps the source of the latest one.

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            for (int s = 0; s < 16; s++) begin
                sgi_src_q[s] <= '0;
            end
        end else if (sgi_req) begin
            sgi_src_q[sgi_id] <= sgi_src;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers.

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            iface_ctrl_q <= IFACE_CTRL_RST;
        end else if (wr_hit(OFF_IFACE_CTRL)) begin
            iface_ctrl_q <= apb_req.pwdata[2:0];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dist_ctrl_q <= DIST_CTRL_RST;
        end else if (wr_hit(OFF_DIST_CTRL)) begin
            dist_ctrl_q <= apb_req.pwdata[1:0];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            group_q <= GROUP_RST;
        end else if (wr_hit(OFF_GROUP)) begin
            group_q <= apb_req.pwdata;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            edge_cfg_q <= EDGE_CFG_RST;
        end else if (wr_hit(OFF_EDGE_CFG)) begin
            edge_cfg_q <= apb_req.pwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data and bus response.

    always_comb begin
        case (apb_req.paddr)
            OFF_IFACE_CTRL: begin
                rd_data = {29'h0000_0000, iface_ctrl_q};
            end
            OFF_DIST_CTRL: begin
                rd_data = {30'h0000_0000, dist_ctrl_q};
            end
            OFF_GROUP: begin
                rd_data = group_q;
            end
            OFF_EDGE_CFG: begin
                rd_data = edge_cfg_q;
            end
            OFF_PENDING: begin
                rd_data = pend_eff;
            end
            OFF_ACTIVE: begin
                rd_data = active_q;
            end
            OFF_ACK, OFF_ALIAS_ACK: begin
                rd_data = ack_val;
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    // Handshake flags and data are kept apart; a refused access still answers, with zero data.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            apb_rsp.pready <= 1'b0;
            apb_rsp.pslverr <= 1'b0;
        end else begin
            apb_rsp.pready <= access;
            apb_rsp.pslverr <= access && !mapped;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            apb_rsp.prdata <= '0;
        end else if (access && !apb_req.pwrite && mapped) begin
            apb_rsp.prdata <= rd_data;
        end else begin
            apb_rsp.prdata <= '0;
        end
    end

    // Announces each acknowledge so that the other interfaces clear their pending latch for the interrupt.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ack_out.valid <= 1'b0;
        end else begin
            ack_out.valid <= take;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ack_out.id <= '0;
        end else begin
            ack_out.id <= take ? ack_val[ID_LSB +: ID_W] : '0;
        end
    end

endmodule // iar_ack_read

// ===== tb/iar_ack_read_monitor.sv
// Port-level assertions for the acknowledge read block.
`timescale 1ns/1ps
module iar_ack_read_monitor
    import iar_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire iar_apb_req_s apb_req,
    input wire iar_apb_rsp_s apb_rsp,
    input wire logic [NUM_IRQ-1:0] irq_in,
    input wire logic prio_ok,
    input wire logic sgi_req,
    input wire logic [3:0] sgi_id,
    input wire logic [CPU_W-1:0] sgi_src,
    input wire logic [NUM_IRQ-1:0] peer_claim,
    input wire iar_ack_s ack_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic rd_any;
    logic rd_ack;
    logic [ID_W-1:0] rid;
    ////////////////////////////////////////
    assign rd_any = apb_rsp.pready && !apb_rsp.pslverr && !apb_req.pwrite;
    assign rd_ack = rd_any && apb_req.paddr == OFF_ACK;
    assign rid = apb_rsp.prdata[ID_W-1:0];
    resv_zero_a: assert property (rd_any && apb_req.paddr[7:3] == 5'h03 |-> apb_rsp.prdata[31:13] == '0)
        else $error("reserved bits set");
    cpu_zero_a: assert property (rd_ack && rid >= ID_SGI_LIMIT |-> apb_rsp.prdata[12:10] == '0)
        else $error("source field set");
    ack_match_a: assert property (rd_ack && rid < ID_FIRST_SPECIAL |-> ack_out.valid && ack_out.id == rid)
        else $error("no matching acknowledge");
    spur_quiet_a: assert property (rd_ack && rid >= ID_FIRST_SPECIAL |-> !ack_out.valid)
        else $error("spurious read acknowledged");
    ack_pulse_a: assert property (ack_out.valid |=> !ack_out.valid [*2])
        else $error("acknowledge pulse too long");
    prio_gate_a: assert property (rd_ack && !$past(prio_ok) |-> rid == ID_SPURIOUS)
        else $error("low priority signalled");
    alias_view_a: assert property (rd_any && apb_req.paddr == OFF_ALIAS_ACK |-> rid != ID_GRP1_ONLY)
        else $error("alias gave secure code");
    claim_bar_a: assert property (ack_out.valid |-> ($past(peer_claim) >> ack_out.id[IDX_W-1:0]) % 2 == 0)
        else $error("claimed interrupt taken");
endmodule // iar_ack_read_monitor

bind iar_ack_read iar_ack_read_monitor iar_ack_read_monitor_i (.clock(clock), .reset(reset),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .irq_in(irq_in), .prio_ok(prio_ok), .sgi_req(sgi_req),
    .sgi_id(sgi_id), .sgi_src(sgi_src), .peer_claim(peer_claim), .ack_out(ack_out));

// ===== tb/iar_cpu_model.sv
// Processor model that issues register transfers and keeps valid acknowledge words.
`timescale 1ns/1ps
module iar_cpu_model
    import iar_pkg::*;
(
    input wire logic clock,
    output iar_apb_req_s apb_req,
    input wire iar_apb_rsp_s apb_rsp
);
    logic [31:0] held_q[$];
    ////////////////////////////////////////
    initial begin
        apb_req = '0;
    end
    // Idle lines carry the inverse of the last request, so a stale value never passes as current.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [2:0] p, input logic [31:0] d);
        @(posedge clock);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, pprot: p, paddr: a, pwdata: d};
        @(posedge clock);
        apb_req.penable <= 1'b1;
        do @(posedge clock); while (apb_rsp.pready !== 1'b1);
        if (!w && a == OFF_ACK && apb_rsp.prdata[ID_W-1:0] < ID_FIRST_SPECIAL) begin
            held_q.push_back(apb_rsp.prdata);
        end
        apb_req <= '{pwrite: ~w, pprot: ~p, paddr: ~a, pwdata: ~d, default: '0};
    endtask
endmodule // iar_cpu_model

// ===== tb/tb_iar_ack_read.sv
// Self-checking testbench for the acknowledge read block.
`timescale 1ns/1ps
module tb_iar_ack_read;
    import iar_pkg::*;
    localparam logic [31:0] SPUR = {22'h0, ID_SPURIOUS};
    logic clock, reset, prio_ok, sgi_req;
    logic [3:0] sgi_id;
    logic [CPU_W-1:0] sgi_src;
    logic [NUM_IRQ-1:0] irq_in, peer_claim;
    iar_apb_req_s apb_req;
    iar_apb_rsp_s apb_rsp;
    iar_ack_s ack_out;
    // A note holds a compare-data flag, the expected error flag and the expected word.
    logic [33:0] exp_q[$];
    logic [33:0] e;
    int n_fail, tests_run, cycles, n_ack;
    int unsigned k, r, s;

    iar_ack_read iar_ack_read_i (.clock(clock), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .irq_in(irq_in), .prio_ok(prio_ok), .sgi_req(sgi_req), .sgi_id(sgi_id), .sgi_src(sgi_src),
        .peer_claim(peer_claim), .ack_out(ack_out));
    iar_cpu_model iar_cpu_model_i (.clock(clock), .apb_req(apb_req), .apb_rsp(apb_rsp));
    ////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Nothing is mapped above the alias word, and both acknowledge words refuse writes.
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [2:0] p = 3'h0);
        exp_q.push_back({1'b1, a > OFF_ALIAS_ACK, x});
        iar_cpu_model_i.xfer(1'b0, a, p, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        exp_q.push_back({1'b0, a[7:3] == 5'h03, 32'h0});
        iar_cpu_model_i.xfer(1'b1, a, 3'h0, d);
    endtask

    always @(posedge clock) begin
        cycles++;
        if (ack_out.valid === 1'b1) begin
            n_ack++;
        end
        if (apb_rsp.pready === 1'b1) begin
            e = exp_q.pop_front();
            tests_run++;
            if (apb_rsp.pslverr !== e[32] || e[33] && apb_rsp.prdata !== e[31:0]) begin
                n_fail++;
                $display("ERROR %0t read %h expected %h", $time, apb_rsp.prdata, e[31:0]);
            end
        end
        if (cycles == 5000) begin
            n_fail++;
            final_report();
        end
    end

    initial begin
        reset = 1'b1;
        prio_ok = 1'b1;
        {sgi_req, sgi_id, sgi_src, irq_in, peer_claim} = '0;
        void'($urandom(84533));
        k = 16 + $urandom % 16;
        r = $urandom % 8;
        s = $urandom % 16;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        rd(OFF_IFACE_CTRL, 32'h0);
        irq_in[k] <= 1'b1;
        rd(OFF_ACK, SPUR);
        wr(OFF_DIST_CTRL, 32'h3);
        rd(OFF_ACK, SPUR);
        wr(OFF_IFACE_CTRL, 32'h7);
        rd(OFF_ACK, SPUR, 3'h2);
        rd(OFF_ALIAS_ACK, SPUR);
        prio_ok <= 1'b0;
        rd(OFF_ACK, SPUR);
        prio_ok <= 1'b1;
        peer_claim[k] <= 1'b1;
        rd(OFF_ACK, SPUR);
        peer_claim <= '0;
        rd(OFF_ACK, 32'(k));
        rd(OFF_ACTIVE, 32'h1 << k);
        rd(OFF_PENDING, 32'h1 << k);
        rd(OFF_ACK, SPUR);
        wr(OFF_ACTIVE, 32'h1 << k);
        wr(OFF_GROUP, 32'h1 << k);
        wr(OFF_IFACE_CTRL, 32'h1);
        rd(OFF_ACK, SPUR, 3'h2);
        wr(OFF_IFACE_CTRL, 32'h3);
        rd(OFF_ACK, {22'h0, ID_GRP1_ONLY});
        rd(OFF_ACK, 32'(k), 3'h2);
        irq_in[k] <= 1'b0;
        wr(OFF_ACTIVE, 32'h1 << k);
        sgi_id <= s[3:0];
        sgi_src <= r[2:0];
        sgi_req <= 1'b1;
        @(posedge clock);
        sgi_req <= 1'b0;
        rd(OFF_ACK, 32'({r[2:0], s[9:0]}));
        rd(OFF_PENDING, 32'h0);
        wr(OFF_EDGE_CFG, 32'h1 << k);
        irq_in[k] <= 1'b1;
        repeat (4) @(posedge clock);
        rd(OFF_ACK, 32'(k), 3'h2);
        rd(OFF_PENDING, 32'h0);
        irq_in[k] <= 1'b0;
        rd(8'h20, 32'h0);
        wr(OFF_ACK, 32'h1);
        repeat (2) @(posedge clock);
        tests_run++;
        if (n_ack != 4) begin
            n_fail++;
            $display("ERROR %0t acknowledge count %0d", $time, n_ack);
        end
        final_report();
    end
endmodule // tb_iar_ack_read
